// File: logic/ert_pkg.sv
// ert_pkg: register map, field positions and reset values of the 8-bit
// reload timer. Assumes a 32-bit AXI4-Lite register port, one word per register.
package ert_pkg;

    // *****************************************************************
    // register indices and address width
    // *****************************************************************
    localparam logic [7:0]  IDX_CONTROL     = 8'h00;
    localparam logic [7:0]  IDX_SHARED_CTL  = 8'h01;
    localparam logic [7:0]  IDX_LOW_HOLD    = 8'h04;
    localparam logic [7:0]  IDX_HIGH_HOLD   = 8'h05;
    localparam logic [7:0]  IDX_WIDE_LOW    = 8'h06;
    localparam logic [7:0]  IDX_CAP_LOW     = 8'h0A;
    localparam logic [7:0]  IDX_CAP_HIGH    = 8'h0B;
    localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h10;
    localparam logic [7:0]  IDX_IRQ_CLEAR   = 8'h11;
    localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'h12;
    localparam int          ADDR_W          = 8;

    // *****************************************************************
    // control fields
    // *****************************************************************
    localparam int          CTL_ENABLE      = 7;
    localparam int          CTL_SINGLE      = 6;
    localparam int          CTL_TIMEOUT     = 5;
    localparam int          CTL_CLK_HI      = 4;
    localparam int          CTL_CLK_LO      = 3;
    localparam int          CTL_CAP_IE      = 2;
    localparam int          CTL_TO_IE       = 1;
    localparam int          SH_PINGPONG_HI  = 3;
    localparam int          SH_PINGPONG_LO  = 2;
    localparam int          SH_INIT_LEVEL   = 1;
    localparam int          ST_TIMEOUT      = 0;
    localparam int          ST_CAPTURE      = 1;

    // *****************************************************************
    // reset values and bus answers
    // *****************************************************************
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam logic [7:0]  COUNT_ONE       = 8'h01;
    localparam logic [7:0]  COUNT_ZERO      = 8'h00;

    typedef struct packed {
        logic       enable;
        logic       single;
        logic       rsvd5;
        logic [1:0] clk_sel;
        logic       cap_ie;
        logic       to_ie;
        logic       bit0;
    } ert_ctl_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic [1:0] pingpong;
        logic       init_level;
        logic       bit0;
    } ert_shared_t;

endpackage

// File: logic/ert_prescale.sv
// ert_prescale: divides the system clock by 1, 2, 4 or 8 into a count strobe.
// Assumes clear is pulsed when counting restarts so the first period is whole.
`timescale 1ns/1ps
module ert_prescale
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        clear,
    input  wire logic [1:0]  sel,
    output logic             tick
);
    import ert_pkg::*;

    logic [2:0] phase;
    logic [2:0] mask;

    assign mask = (sel == 2'h0) ? 3'h0 : (sel == 2'h1) ? 3'h1 : (sel == 2'h2) ? 3'h3 : 3'h7;
    assign tick = ((phase & mask) == mask) && !clear;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            phase <= 3'h0;
        else if (clear)
            phase <= 3'h0;
        else
            phase <= phase + 3'h1;
    end

endmodule // ert_prescale

// File: logic/ert_timer.sv
// ert_timer: 8-bit reload counter/timer with level-driven hold reload,
// capture of high/low durations and an AXI4-Lite register port.
// Assumes capture_in is synchronous to sys_clk.
//
// Functional notes
// - enable drives output to initial level bit
// - enable loads low or high hold by level
// - single pass stops at zero, toggles, flags
// - first modulo-N terminal count raises no interrupt
// - modulo-N reloads hold chosen by new output
// - each later countdown toggles, flags, maybe interrupts
// - hold writes apply at next reload only
// - count zero wraps through FF, FE
// - timeout flag cleared by writing one
// - control bit two masks capture interrupt
// - disable then enable reloads initial value
// - capture high and low input durations
`timescale 1ns/1ps
module ert_timer
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        capture_in,
    output logic             timer_output,
    output logic [1:0]       pingpong_mode,
    output logic [7:0]       wide_low_value,
    output logic             irq
);
    import ert_pkg::*;

    // *****************************************************************
    // registers
    // *****************************************************************
    ert_ctl_t    ctl;
    ert_shared_t shared_ctl;
    logic [7:0]  low_level_value;
    logic [7:0]  high_level_value;
    logic [7:0]  cap_high;
    logic [7:0]  cap_low;
    logic [1:0]  irq_en;
    logic        to_flag;
    logic        cap_flag;
    logic [7:0]  count;
    logic [7:0]  accum;
    logic        running;
    logic        first_pass;
    logic        cap_prev;

    // *****************************************************************
    // AXI4-Lite write and read channels
    // *****************************************************************
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [7:0]        w_byte;
    logic              w_strb0;
    logic              w_held;
    logic              do_write;
    logic [ADDR_W-1:0] wr_idx;
    logic [ADDR_W-1:0] rd_idx;
    logic              wr_hit;
    logic              rd_hit;
    logic [7:0]        rd_byte;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx        = {2'h0, aw_addr[ADDR_W-1:2]};
    assign rd_idx        = {2'h0, s_axi_araddr[ADDR_W-1:2]};

    assign wr_hit = (aw_addr[1:0] == 2'h0) && (wr_idx == IDX_CONTROL || wr_idx == IDX_SHARED_CTL
                    || wr_idx == IDX_LOW_HOLD || wr_idx == IDX_HIGH_HOLD || wr_idx == IDX_WIDE_LOW
                    || wr_idx == IDX_CAP_LOW || wr_idx == IDX_CAP_HIGH || wr_idx == IDX_IRQ_STATUS
                    || wr_idx == IDX_IRQ_CLEAR || wr_idx == IDX_IRQ_ENABLE);
    assign rd_hit = (s_axi_araddr[1:0] == 2'h0) && (rd_idx == IDX_CONTROL
                    || rd_idx == IDX_SHARED_CTL || rd_idx == IDX_LOW_HOLD
                    || rd_idx == IDX_HIGH_HOLD || rd_idx == IDX_WIDE_LOW || rd_idx == IDX_CAP_LOW
                    || rd_idx == IDX_CAP_HIGH || rd_idx == IDX_IRQ_STATUS
                    || rd_idx == IDX_IRQ_CLEAR || rd_idx == IDX_IRQ_ENABLE);

    // capture registers and status are read-only; the clear register reads zero
    assign rd_byte = (rd_idx == IDX_CONTROL)    ? {ctl.enable, ctl.single, to_flag, ctl.clk_sel,
                                                   ctl.cap_ie, ctl.to_ie, ctl.bit0} :
                     (rd_idx == IDX_SHARED_CTL) ? shared_ctl :
                     (rd_idx == IDX_LOW_HOLD)   ? low_level_value :
                     (rd_idx == IDX_HIGH_HOLD)  ? high_level_value :
                     (rd_idx == IDX_WIDE_LOW)   ? wide_low_value :
                     (rd_idx == IDX_CAP_LOW)    ? cap_low :
                     (rd_idx == IDX_CAP_HIGH)   ? cap_high :
                     (rd_idx == IDX_IRQ_STATUS) ? {6'h00, cap_flag, to_flag} :
                     (rd_idx == IDX_IRQ_ENABLE) ? {6'h00, irq_en} : 8'h00;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_held      <= 1'b0;
            aw_addr      <= '0;
            w_held       <= 1'b0;
            w_byte       <= 8'h00;
            w_strb0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[ADDR_W-1:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_strb0 <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // *****************************************************************
    // register writes
    // *****************************************************************
    logic wr_en;
    logic wr_ctl;
    logic start;
    logic stop;

    assign wr_en  = do_write && w_strb0;
    assign wr_ctl = wr_en && (wr_idx == IDX_CONTROL);
    assign start  = wr_ctl && w_byte[CTL_ENABLE] && !ctl.enable;
    assign stop   = wr_ctl && !w_byte[CTL_ENABLE];

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl              <= RST_BYTE;
            shared_ctl       <= RST_BYTE;
            low_level_value  <= RST_BYTE;
            high_level_value <= RST_BYTE;
            wide_low_value   <= RST_BYTE;
            irq_en           <= 2'h0;
        end
        else if (wr_en)
        begin
            if (wr_idx == IDX_CONTROL)
                ctl <= {w_byte[7:6], 1'b0, w_byte[4:0]};
            if (wr_idx == IDX_SHARED_CTL)
                shared_ctl <= {4'h0, w_byte[3:0]};
            if (wr_idx == IDX_LOW_HOLD)
                low_level_value <= w_byte;
            if (wr_idx == IDX_HIGH_HOLD)
                high_level_value <= w_byte;
            if (wr_idx == IDX_WIDE_LOW)
                wide_low_value <= w_byte;
            if (wr_idx == IDX_IRQ_ENABLE)
                irq_en <= w_byte[1:0];
        end
    end

    assign pingpong_mode = shared_ctl.pingpong;

    // *****************************************************************
    // counter core
    // *****************************************************************
    logic       tick;
    logic       term;
    logic       flag_ev;
    logic       next_level;
    logic [7:0] reload_val;
    logic [7:0] start_val;
    logic       to_clr;
    logic       cap_clr;
    logic       cap_edge;

    ert_prescale u_prescale
    (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clear   (start),
        .sel     (ctl.clk_sel),
        .tick    (tick)
    );

    assign term       = running && tick && (count == COUNT_ONE);
    assign next_level = !timer_output;
    assign reload_val = next_level ? high_level_value : low_level_value;
    assign start_val  = shared_ctl.init_level ? high_level_value : low_level_value;
    assign flag_ev    = term && (ctl.single || !first_pass);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count        <= COUNT_ZERO;
            running      <= 1'b0;
            first_pass   <= 1'b0;
            timer_output <= 1'b0;
        end
        else if (start)
        begin
            timer_output <= shared_ctl.init_level;
            count        <= start_val;
            running      <= 1'b1;
            first_pass   <= 1'b1;
        end
        else if (stop)
            running <= 1'b0;
        else if (term)
        begin
            timer_output <= next_level;
            first_pass   <= 1'b0;
            if (ctl.single)
            begin
                count   <= COUNT_ZERO;
                running <= 1'b0;
            end
            else
                count <= reload_val;
        end
        else if (running && tick)
            count <= count - 8'h01;
    end

    // *****************************************************************
    // capture of input durations
    // *****************************************************************
    assign cap_edge = running && (capture_in != cap_prev);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cap_prev <= 1'b0;
            accum    <= 8'h00;
            cap_high <= RST_BYTE;
            cap_low  <= RST_BYTE;
        end
        else
        begin
            cap_prev <= capture_in;
            if (cap_edge)
            begin
                if (cap_prev)
                    cap_high <= accum;
                else
                    cap_low <= accum;
                accum <= 8'h00;
            end
            else if (running && tick)
                accum <= accum + 8'h01;
        end
    end

    // *****************************************************************
    // flags and interrupt
    // *****************************************************************
    assign to_clr  = (wr_ctl && w_byte[CTL_TIMEOUT])
                     || (wr_en && wr_idx == IDX_IRQ_CLEAR && w_byte[ST_TIMEOUT]);
    assign cap_clr = wr_en && wr_idx == IDX_IRQ_CLEAR && w_byte[ST_CAPTURE];

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            to_flag  <= 1'b0;
            cap_flag <= 1'b0;
        end
        else
        begin
            to_flag  <= flag_ev || (to_flag && !to_clr);
            cap_flag <= cap_edge || (cap_flag && !cap_clr);
        end
    end

    assign irq = (to_flag && irq_en[ST_TIMEOUT] && ctl.to_ie)
                 || (cap_flag && irq_en[ST_CAPTURE] && ctl.cap_ie);

    // *****************************************************************
    // checks
    // *****************************************************************
    start_level_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        start |=> timer_output == $past(shared_ctl.init_level))
        else $error("output not at initial level after enable");

    start_load_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        start |=> count == $past(start_val) && running)
        else $error("wrong initial load");

    single_stop_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (term && ctl.single && !start && !stop) |=> !running && to_flag
            && timer_output != $past(timer_output))
        else $error("single pass did not stop and flag");

    first_quiet_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (term && !ctl.single && first_pass && !to_flag && !start && !stop) |=> !to_flag)
        else $error("first modulo terminal count raised flag");

    modn_reload_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (term && !ctl.single && !start && !stop) |=> count == (timer_output
            ? $past(high_level_value) : $past(low_level_value)))
        else $error("modulo reload from wrong hold");

    irq_gate_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (to_flag && !ctl.to_ie && !(cap_flag && ctl.cap_ie && irq_en[ST_CAPTURE])) |-> !irq)
        else $error("timeout interrupt not masked");

    wrap_zero_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (running && tick && count == COUNT_ZERO && !start && !stop) |=> count == 8'hFF)
        else $error("zero count did not wrap");

    flag_clear_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (to_flag && to_clr && !flag_ev) ##1 !flag_ev [*2] |-> !to_flag)
        else $error("timeout flag not cleared");

    cap_mask_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!ctl.cap_ie && !(to_flag && ctl.to_ie && irq_en[ST_TIMEOUT])) |-> !irq)
        else $error("capture interrupt not masked");

    restart_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        stop ##[2:40] start |=> count == $past(start_val))
        else $error("restart did not reload");

    hold_keep_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (running && tick && !term && !start && !stop && count != COUNT_ZERO)
            |=> count == $past(count) - 8'h01)
        else $error("count disturbed outside reload");

endmodule // ert_timer

// File: verification/ert_tb.sv
// tb: self-checking bench for the 8-bit reload timer, driven through its AXI4-Lite port.
// Assumes ert_pkg and ert_timer are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module tb;
    import ert_pkg::*;
    // *****************************************************************
    // signals and register addresses
    // *****************************************************************
    localparam logic [31:0] A_CTL  = 32'(IDX_CONTROL) << 2;
    localparam logic [31:0] A_SHR  = 32'(IDX_SHARED_CTL) << 2;
    localparam logic [31:0] A_LOW  = 32'(IDX_LOW_HOLD) << 2;
    localparam logic [31:0] A_HIGH = 32'(IDX_HIGH_HOLD) << 2;
    localparam logic [31:0] A_CAPH = 32'(IDX_CAP_HIGH) << 2;
    localparam logic [31:0] A_STAT = 32'(IDX_IRQ_STATUS) << 2;
    localparam logic [31:0] A_ICLR = 32'(IDX_IRQ_CLEAR) << 2;
    localparam logic [31:0] A_IEN  = 32'(IDX_IRQ_ENABLE) << 2;
    typedef struct { logic [31:0] addr; logic [31:0] wval; logic [31:0] rval; logic [1:0] resp; }
        ert_reg_row_t;
    typedef struct { logic [1:0] sel; logic [7:0] hold; int gap; } ert_pre_row_t;
    logic        sys_clk, rst_b, capture_in, timer_output, irq;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs, pingpong_mode;
    logic [7:0]  wide_low_value;
    int          n_fail, total_checks, cyc, t0, t1, t2, ts;
    ert_reg_row_t regs [7] = '{'{32'h10, 32'hA5, 32'hA5, RESP_OKAY},
        '{32'h14, 32'h5A, 32'h5A, RESP_OKAY}, '{32'h18, 32'h3C, 32'h3C, RESP_OKAY},
        '{32'h04, 32'h0D, 32'h0D, RESP_OKAY}, '{32'h28, 32'hFF, 32'h00, RESP_OKAY},
        '{32'h44, 32'h01, 32'h00, RESP_OKAY}, '{32'h30, 32'hFF, 32'h00, RESP_SLVERR}};
    ert_pre_row_t pre [5] = '{'{2'h0, 8'h04, 4}, '{2'h1, 8'h04, 8}, '{2'h2, 8'h04, 16},
        '{2'h3, 8'h03, 24}, '{2'h0, 8'h00, 256}};

    ert_timer ert_timer_inst (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .capture_in(capture_in), .timer_output(timer_output),
        .pingpong_mode(pingpong_mode), .wide_low_value(wide_low_value), .irq(irq));

    // *****************************************************************
    // bus, compare and wait tasks
    // *****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge sys_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (pa || pw)
        begin
            @(negedge sys_clk);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge sys_clk);
            if (ta) begin awvalid <= 1'b0; pa = 1'b0; end
            if (tw) begin wvalid <= 1'b0; pw = 1'b0; end
        end
        do @(negedge sys_clk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge sys_clk);
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(negedge sys_clk); while (arready !== 1'b1);
        @(posedge sys_clk);
        arvalid <= 1'b0;
        do @(negedge sys_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge sys_clk);
        rready <= 1'b0;
    endtask

    // waits at falling edges while the output still shows lvl; gives the cycle of change
    task automatic wait_toggle(input logic lvl, output int t);
        int n;
        n = 0;
        do begin @(negedge sys_clk); n++; end while (timer_output === lvl && n < 600);
        t = cyc;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // *****************************************************************
    // clock and watchdog
    // *****************************************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail++;
            tally_and_finish;
        end
    end

    // *****************************************************************
    // test sequence
    // *****************************************************************
    initial
    begin
        {rst_b, capture_in, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hF;
        n_fail = 0;
        total_checks = 0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        foreach (regs[i])
        begin
            rdr(regs[i].addr, rd, rs);
            chk("reset value", 32'h0, rd);
            chk("read resp", regs[i].resp, 32'(rs));
            wr(regs[i].addr, regs[i].wval, rs);
            chk("write resp", regs[i].resp, 32'(rs));
            rdr(regs[i].addr, rd, rs);
            chk("readback", regs[i].rval, rd);
        end
        chk("wide low port", 32'h3C, 32'(wide_low_value));
        wr(A_CTL, 32'h40, rs);
        wr(A_CTL, 32'hC0, rs);
        chk("pingpong port", 32'h3, 32'(pingpong_mode));
        wr(A_SHR, 32'h0, rs);
        $display("test registers done");
        foreach (pre[i])
        begin
            wr(A_CTL, 32'h0, rs);
            wr(A_LOW, 32'(pre[i].hold), rs);
            wr(A_HIGH, 32'(pre[i].hold), rs);
            wr(A_CTL, 32'h80 | (32'(pre[i].sel) << 3), rs);
            wait_toggle(1'b0, t0);
            wait_toggle(1'b1, t1);
            wait_toggle(1'b0, t2);
            chk("toggle gap a", 32'(pre[i].gap), 32'(t1 - t0));
            chk("toggle gap b", 32'(pre[i].gap), 32'(t2 - t1));
        end
        $display("test prescale done");
        wr(A_CTL, 32'h20, rs);
        wr(A_LOW, 32'd20, rs);
        wr(A_IEN, 32'h1, rs);
        wr(A_CTL, 32'hC2, rs);
        @(negedge sys_clk);
        chk("single start out", 32'h0, 32'(timer_output));
        chk("single start irq", 32'h0, 32'(irq));
        wait_toggle(1'b0, t0);
        repeat (40) @(negedge sys_clk);
        chk("single end out", 32'h1, 32'(timer_output));
        chk("single irq", 32'h1, 32'(irq));
        rdr(A_CTL, rd, rs);
        chk("flag set", 32'hE2, rd);
        wr(A_CTL, 32'hC2, rs);
        rdr(A_CTL, rd, rs);
        chk("flag kept", 32'hE2, rd);
        wr(A_CTL, 32'hE2, rs);
        rdr(A_CTL, rd, rs);
        chk("flag cleared", 32'hC2, rd);
        chk("irq cleared", 32'h0, 32'(irq));
        $display("test single pass done");
        wr(A_CTL, 32'h0, rs);
        wr(A_SHR, 32'h2, rs);
        wr(A_HIGH, 32'd10, rs);
        wr(A_LOW, 32'd12, rs);
        wr(A_CTL, 32'h82, rs);
        @(negedge sys_clk);
        chk("modulo start out", 32'h1, 32'(timer_output));
        wait_toggle(1'b1, t0);
        rdr(A_CTL, rd, rs);
        chk("first terminal flag", 32'h82, rd);
        chk("first terminal irq", 32'h0, 32'(irq));
        wr(A_HIGH, 32'd20, rs);
        wait_toggle(1'b0, t1);
        chk("low phase", 32'd12, 32'(t1 - t0));
        chk("modulo irq", 32'h1, 32'(irq));
        wait_toggle(1'b1, t2);
        chk("new high phase", 32'd20, 32'(t2 - t1));
        $display("test modulo done");
        wr(A_CTL, 32'h02, rs);
        wr(A_SHR, 32'h2, rs);
        wr(A_CTL, 32'h82, rs);
        ts = cyc;
        @(negedge sys_clk);
        chk("restart out", 32'h1, 32'(timer_output));
        wait_toggle(1'b1, t0);
        chk("restart reload", 32'h1, 32'((t0 - ts) <= 20 && (t0 - ts) >= 17));
        $display("test restart done");
        wr(A_CTL, 32'h80, rs);
        wr(A_ICLR, 32'h3, rs);
        wr(A_IEN, 32'h2, rs);
        @(posedge sys_clk);
        capture_in <= 1'b1;
        repeat (10) @(posedge sys_clk);
        capture_in <= 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("capture masked", 32'h0, 32'(irq));
        rdr(A_STAT, rd, rs);
        chk("capture flag", 32'h2, rd & 32'h2);
        wr(A_CTL, 32'h84, rs);
        chk("capture irq", 32'h1, 32'(irq));
        rdr(A_CAPH, rd, rs);
        chk("capture high", 32'h1, 32'(rd >= 32'd9 && rd <= 32'd11));
        wr(A_ICLR, 32'h2, rs);
        chk("capture cleared", 32'h0, 32'(irq));
        $display("test capture done");
        wr(A_CTL, 32'h00, rs);
        wr(A_CTL, 32'h86, rs);
        capture_in <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("run out", 32'h1, 32'(timer_output));
        chk("run irq", 32'h1, 32'(irq));
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(negedge sys_clk);
        chk("reset out", 32'h0, 32'(timer_output));
        chk("reset irq", 32'h0, 32'(irq));
        @(posedge sys_clk);
        rst_b <= 1'b1;
        rdr(A_CTL, rd, rs);
        chk("reset control", 32'h0, rd);
        $display("test reset done");
        tally_and_finish;
    end
endmodule // tb
